// >>> wiu_pkg.sv
/*
 * Package for the wake line unit: register offsets, field positions,
 * reset values, stop-sequence states and timing.
 * Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
 */
package wiu_pkg;
    localparam int          NUM_LINES      = 16;
    localparam int          NUM_EXT_GRP    = 4;
    localparam int          NUM_INT_LINES  = 10;
    localparam int          EXT_SOLO_IDX   = 4;
    localparam int          INT_BASE_IDX   = 5;

    localparam logic [7:0]  OFF_CONTROL    = 8'h00;
    localparam logic [7:0]  OFF_MASK       = 8'h04;
    localparam logic [7:0]  OFF_EDGE       = 8'h08;
    localparam logic [7:0]  OFF_PENDING    = 8'h0C;

    localparam int          BIT_WAKE_MODE  = 0;
    localparam int          BIT_INT_EN     = 1;
    localparam int          BIT_STOP       = 2;

    localparam logic [15:0] RST_CONTROL    = 16'h0000;
    localparam logic [15:0] RST_MASK       = 16'h0000;
    localparam logic [15:0] RST_EDGE       = 16'h0000;
    localparam logic [15:0] RST_PENDING    = 16'h0000;

    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          SEQ_TIMEOUT_CYC = 64;
    localparam logic [6:0]  SEQ_TIMEOUT    = 7'(SEQ_TIMEOUT_CYC);

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        WIU_SEQ_IDLE,
        WIU_SEQ_ONE,
        WIU_SEQ_ZERO
    } wiu_seq_e;
endpackage : wiu_pkg

// >>> wiu_wake_line_unit.sv
/*
 * Wake line unit: sixteen edge-triggered lines (line 15 has no source), per-line pending, mask
 * and edge-select registers, control word and guarded stop-entry.
 * Assumes an AXI4-Lite master on sys_clk; external lines are async pins,
 * internal lines come from logic on sys_clk.
 */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module wiu_wake_line_unit
    import wiu_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Wake and interrupt lines
    input  wire logic [4:0]  ext_line_pin,
    input  wire logic [9:0]  int_line_sig,
    // Interrupt controller channels
    output logic             controller_channel_zero,
    output logic             controller_channel_one,
    output logic             controller_channel_two,
    // Power control
    output logic             stop_request,
    output logic             wake_event
);
    import wiu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Line synchronisers and edge detect

    logic [4:0]  ext_s1_r, ext_s2_r;
    logic [15:0] line_lvl, line_prev_r, line_edge;
    logic [15:0] line_pending_flags_r, line_pending_flags_nxt;
    logic [15:0] line_request_mask_r, line_request_mask_nxt;
    logic [15:0] line_edge_select_r, line_edge_select_nxt;
    logic        wake_mode_select_r, wake_mode_select_nxt;
    logic        int_en_r, int_en_nxt;
    logic        stop_bit_r, stop_bit_nxt;

    // Pins pass two flops; internal signals are already on sys_clk
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ext_s1_r    <= 5'h00;
            ext_s2_r    <= 5'h00;
            line_prev_r <= 16'h0000;
        end else begin
            ext_s1_r    <= ext_line_pin;
            ext_s2_r    <= ext_s1_r;
            line_prev_r <= line_lvl;
        end
    end

    // Line 15 has no source; a constant 0 never makes an edge
    assign line_lvl = {1'b0, int_line_sig, ext_s2_r};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_edge
            // 1 selects rising, 0 falling
            assign line_edge[gi] = line_edge_select_r[gi]
                                 ? ( line_lvl[gi] & ~line_prev_r[gi])
                                 : (~line_lvl[gi] &  line_prev_r[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        bvalid_nxt, rvalid_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic        bvalid_r, rvalid_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic        wr_fire, wr_ctl, wr_mask, wr_edge, wr_pend, wr_hit;
    logic [15:0] wr_val;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    assign wr_fire = aw_held_r && w_held_r;
    assign wr_val  = {w_strb_r[1] ? w_data_r[15:8] : 8'h00,
                      w_strb_r[0] ? w_data_r[7:0]  : 8'h00};
    assign wr_ctl  = wr_fire && (aw_addr_r[7:2] == OFF_CONTROL[7:2]) && w_strb_r[0];
    assign wr_mask = wr_fire && (aw_addr_r[7:2] == OFF_MASK[7:2]);
    assign wr_edge = wr_fire && (aw_addr_r[7:2] == OFF_EDGE[7:2]);
    assign wr_pend = wr_fire && (aw_addr_r[7:2] == OFF_PENDING[7:2]);
    assign wr_hit  = wr_fire && (aw_addr_r[7:2] <= OFF_PENDING[7:2]);

    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
    end

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            if (s_axi_araddr[7:2] == OFF_CONTROL[7:2]) begin
                rdata_nxt = {29'h0, stop_bit_r, int_en_r, wake_mode_select_r};
            end else if (s_axi_araddr[7:2] == OFF_MASK[7:2]) begin
                rdata_nxt = {16'h0000, line_request_mask_r};
            end else if (s_axi_araddr[7:2] == OFF_EDGE[7:2]) begin
                rdata_nxt = {16'h0000, line_edge_select_r};
            end else if (s_axi_araddr[7:2] == OFF_PENDING[7:2]) begin
                rdata_nxt = {16'h0000, line_pending_flags_r};
            end else begin
                rdata_nxt = 32'h0000_0000;
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r  <= w_held_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line registers and request routing

    logic [15:0] req_active;

    always_comb begin
        line_request_mask_nxt = wr_mask ? wr_val : line_request_mask_r;
        line_edge_select_nxt  = wr_edge ? wr_val : line_edge_select_r;
        wake_mode_select_nxt  = wr_ctl ? w_data_r[BIT_WAKE_MODE] : wake_mode_select_r;
        int_en_nxt            = wr_ctl ? w_data_r[BIT_INT_EN] : int_en_r;
        // Write 1 clears; an edge in the same cycle wins
        line_pending_flags_nxt = line_pending_flags_r;
        if (wr_pend) begin
            line_pending_flags_nxt = line_pending_flags_r & ~wr_val;
        end
        // Edges ignored during an edge-select write
        if (!wr_edge) begin
            line_pending_flags_nxt = line_pending_flags_nxt | line_edge;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            line_request_mask_r  <= RST_MASK;
            line_edge_select_r   <= RST_EDGE;
            line_pending_flags_r <= RST_PENDING;
            wake_mode_select_r   <= RST_CONTROL[BIT_WAKE_MODE];
            int_en_r             <= RST_CONTROL[BIT_INT_EN];
        end else begin
            line_request_mask_r  <= line_request_mask_nxt;
            line_edge_select_r   <= line_edge_select_nxt;
            line_pending_flags_r <= line_pending_flags_nxt;
            wake_mode_select_r   <= wake_mode_select_nxt;
            int_en_r             <= int_en_nxt;
        end
    end

    assign req_active = line_pending_flags_r & line_request_mask_r;

    // Channel grouping
    assign controller_channel_zero = int_en_r && |req_active[NUM_EXT_GRP-1:0];
    assign controller_channel_one  = int_en_r && req_active[EXT_SOLO_IDX];
    assign controller_channel_two  = int_en_r && |req_active[NUM_LINES-1:INT_BASE_IDX];

    // Raw masked edge lets the clock controller restart while stopped
    assign wake_event = wake_mode_select_r &&
                        (|req_active || |(line_edge & line_request_mask_r));

    ////////////////////////////////////////////////////////////////////////
    // Stop-entry sequence

    wiu_seq_e   seq_r, seq_nxt;
    logic [6:0] seq_cnt_r, seq_cnt_nxt;
    logic       stop_ok;

    assign stop_ok = wake_mode_select_r && (req_active == 16'h0000)
                   && (line_request_mask_r != 16'h0000);

    always_comb begin
        seq_nxt      = seq_r;
        seq_cnt_nxt  = (seq_r == WIU_SEQ_IDLE) ? 7'h00 : seq_cnt_r + 7'h01;
        stop_bit_nxt = stop_bit_r;
        if (wr_ctl) begin
            // Writes do not restart the timer: 64 cycles bound the whole sequence
            case (seq_r)
                WIU_SEQ_IDLE: begin
                    if (w_data_r[BIT_STOP]) begin
                        seq_nxt      = WIU_SEQ_ONE;
                        stop_bit_nxt = 1'b1;
                    end
                end
                WIU_SEQ_ONE: begin
                    // Second one from here would be a bad pair
                    seq_nxt      = w_data_r[BIT_STOP] ? WIU_SEQ_IDLE : WIU_SEQ_ZERO;
                    stop_bit_nxt = 1'b0;
                end
                WIU_SEQ_ZERO: begin
                    seq_nxt      = WIU_SEQ_IDLE;
                    stop_bit_nxt = w_data_r[BIT_STOP] && stop_ok;
                end
                default: begin
                    seq_nxt = WIU_SEQ_IDLE;
                end
            endcase
        end else if (wr_hit && seq_r != WIU_SEQ_IDLE) begin
            seq_nxt      = WIU_SEQ_IDLE;
            stop_bit_nxt = 1'b0;
        end else if (seq_r != WIU_SEQ_IDLE && seq_cnt_r >= SEQ_TIMEOUT - 7'h01) begin
            seq_nxt      = WIU_SEQ_IDLE;
            stop_bit_nxt = 1'b0;
        end else if (seq_r == WIU_SEQ_IDLE && stop_bit_r && wake_event) begin
            stop_bit_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            seq_r      <= WIU_SEQ_IDLE;
            seq_cnt_r  <= 7'h00;
            stop_bit_r <= RST_CONTROL[BIT_STOP];
        end else begin
            seq_r      <= seq_nxt;
            seq_cnt_r  <= seq_cnt_nxt;
            stop_bit_r <= stop_bit_nxt;
        end
    end

    // Only a completed sequence raises the request, not the first 1
    assign stop_request = stop_bit_r && (seq_r == WIU_SEQ_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    stop_needs_ok_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(stop_request) |-> $past(stop_ok)) else $error("stop without conditions");
    seq_timeout_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        seq_cnt_r <= SEQ_TIMEOUT) else $error("sequence timer overrun");
    mask_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (line_request_mask_r == 16'h0000) |-> !controller_channel_zero
        && !controller_channel_one && !controller_channel_two) else $error("masked request");
    int_en_gate_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !int_en_r |-> !controller_channel_zero && !controller_channel_one
        && !controller_channel_two)
        else $error("channel without enable");
    pend_sticky_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !wr_pend |=> (line_pending_flags_r & $past(line_pending_flags_r))
        == $past(line_pending_flags_r)) else $error("pending lost");
    edge_sets_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (line_edge != 16'h0000 && !wr_edge) |=> (line_pending_flags_r & $past(line_edge))
        == $past(line_edge)) else $error("edge not caught");
    wake_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (stop_request && wake_event && !wr_hit) |=> !stop_bit_r) else $error("stop held");
    zero_pair_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (wr_ctl && seq_r == WIU_SEQ_ZERO && !w_data_r[BIT_STOP]) |=> seq_r == WIU_SEQ_IDLE
        && !stop_bit_r) else $error("zero pair kept sequence");
    wake_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !wake_mode_select_r |-> !wake_event) else $error("wake without mode");

    stop_cov_c:    cover property (@(posedge sys_clk) disable iff (!resetn) $rose(stop_request));
    timeout_cov_c: cover property (@(posedge sys_clk) disable iff (!resetn)
        seq_r != WIU_SEQ_IDLE && seq_cnt_r == SEQ_TIMEOUT - 7'h01);
    irq_cov_c:     cover property (@(posedge sys_clk) disable iff (!resetn)
        controller_channel_two);
endmodule : wiu_wake_line_unit

// >>> wiu_line_model.sv
/*
 * Far-side model of the wake line unit: external wake pins and the
 * on-chip signals that feed the internal lines.
 * Assumes the bench sets the wanted levels on ext_req and int_req.
 */
`timescale 1ns/10ps
module wiu_line_model (
    // Clock
    input  wire logic       sys_clk,
    // Wanted levels from the bench
    input  wire logic [4:0] ext_req,
    input  wire logic [9:0] int_req,
    // Levels toward the unit
    output logic      [4:0] ext_line_pin,
    output logic      [9:0] int_line_sig
);
    initial begin
        ext_line_pin = 5'h00;
        int_line_sig = 10'h000;
    end

    ////////////////////////////////////////////////////////////////////
    // Pins are asynchronous: move them well away from the clock edge
    always @(ext_req) begin
        ext_line_pin <= #7 ext_req;
    end

    // On-chip sources change with the system clock
    always @(posedge sys_clk) begin
        int_line_sig <= int_req;
    end
endmodule : wiu_line_model

// >>> test_wakeup_interrupt_unit.sv
/*
 * Bench for the wake line unit: register bus, line routing, stop entry.
 * Assumes wiu_pkg, the unit and the line model are compiled first.
 */
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin \
    miscompares++; $display("CHECK FAILED %0t %s", $time, msg); end end
module test_wakeup_interrupt_unit;
    import wiu_pkg::*;
    logic        sys_clk, resetn, s_axi_bready, s_axi_rready;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        controller_channel_zero, controller_channel_one, controller_channel_two;
    logic        stop_request, wake_event;
    logic [4:0]  ext_line_pin, ext_req;
    logic [9:0]  int_line_sig, int_req;
    int          miscompares = 0;
    int          comparisons = 0;
    wire logic [2:0] chan_v = {controller_channel_two, controller_channel_one,
                               controller_channel_zero};

    wiu_wake_line_unit dut_u (
        .sys_clk, .resetn,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .ext_line_pin, .int_line_sig,
        .controller_channel_zero, .controller_channel_one, .controller_channel_two,
        .stop_request, .wake_event
    );
    wiu_line_model line_u (.sys_clk, .ext_req, .int_req, .ext_line_pin, .int_line_sig);

    initial begin
        sys_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus master: ready sampled before the edge's own updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n    = 0;
        logic aw_p = 1'b1;
        logic w_p  = 1'b1;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        while (n < 40) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_bvalid === 1'b1 && !aw_p && !w_p) break;
            if (aw_p && s_axi_awready === 1'b1) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        wresp = s_axi_bresp;
        `CHK(n < 40, 1'b1, "write got no answer")
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int   n    = 0;
        logic ar_p = 1'b1;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        while (n < 40) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_rvalid === 1'b1 && !ar_p) break;
            if (ar_p && s_axi_arready === 1'b1) begin
                ar_p = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        rdat  = s_axi_rdata;
        rresp = s_axi_rresp;
        `CHK(n < 40, 1'b1, "read got no answer")
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
        rd(a);
        `CHK(rdat, e, m)
    endtask : rchk

    // Six edges cover the two-flop sync plus edge detect
    task automatic line_to(input int ln, input logic v);
        if (ln < 5) ext_req[ln] <= v;
        else int_req[ln - 5] <= v;
        repeat (6) @(posedge sys_clk);
    endtask : line_to

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk(OFF_CONTROL, 32'h0, "control reset");
        rchk(OFF_MASK, 32'h0, "mask reset");
        rchk(OFF_EDGE, 32'h0, "edge reset");
        rchk(OFF_PENDING, 32'h0, "pending reset");
        wr(OFF_MASK, 32'hFFFF_FFFF);
        `CHK(wresp, RESP_OKAY, "mapped write okay")
        rchk(OFF_MASK, 32'h0000_FFFF, "mask width");
        `CHK(rresp, RESP_OKAY, "mapped read okay")
        wr(OFF_EDGE, 32'h0000_A5C3);
        rchk(OFF_EDGE, 32'h0000_A5C3, "edge readback");
        wr(8'h10, 32'h0000_FFFF);
        `CHK(wresp, RESP_SLVERR, "unmapped write")
        rd(8'h10);
        `CHK({rresp, rdat}, {RESP_SLVERR, 32'h0}, "unmapped read")
        $display("test regs done");
    endtask : t_regs

    task automatic t_lines();
        int         ln[3] = '{0, 4, 5};
        logic [2:0] ch[3] = '{3'b001, 3'b010, 3'b100};
        wr(OFF_EDGE, 32'h0000_FFFF);
        wr(OFF_CONTROL, 32'h2);
        for (int i = 0; i < 3; i++) begin
            line_to(ln[i], 1'b1);
            `CHK(chan_v, ch[i], "channel routing")
            rchk(OFF_PENDING, 32'h1 << ln[i], "pending on rise");
            line_to(ln[i], 1'b0);
            wr(OFF_PENDING, 32'h1 << ln[i]);
            rchk(OFF_PENDING, 32'h0, "pending cleared");
            `CHK(chan_v, 3'b000, "channel drops")
        end
        wr(OFF_EDGE, 32'h0000_FFFE);
        line_to(0, 1'b1);
        rchk(OFF_PENDING, 32'h0, "rise ignored");
        line_to(0, 1'b0);
        rchk(OFF_PENDING, 32'h1, "fall sets pending");
        wr(OFF_MASK, 32'h0000_FFFE);
        `CHK(chan_v, 3'b000, "masked line quiet")
        wr(OFF_MASK, 32'h0000_FFFF);
        `CHK(chan_v, 3'b001, "unmasked line requests")
        wr(OFF_CONTROL, 32'h0);
        `CHK(chan_v, 3'b000, "interrupts disabled")
        wr(OFF_PENDING, 32'h1);
        $display("test lines done");
    endtask : t_lines

    ////////////////////////////////////////////////////////////////////
    task automatic t_stop_ok();
        logic seen = 1'b0;
        wr(OFF_EDGE, 32'h0000_FFFF);
        wr(OFF_MASK, 32'h0000_0001);
        wr(OFF_CONTROL, 32'h5);
        rchk(OFF_CONTROL, 32'h5, "stop after first write");
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h5);
        `CHK(stop_request, 1'b1, "stop entered")
        rchk(OFF_CONTROL, 32'h5, "stop bit polled");
        ext_req[0] <= 1'b1;
        repeat (8) begin
            @(posedge sys_clk);
            if (wake_event === 1'b1) seen = 1'b1;
        end
        `CHK(seen, 1'b1, "wake event")
        `CHK(stop_request, 1'b0, "wake leaves stop")
        `CHK(chan_v, 3'b000, "wake without interrupt")
        line_to(0, 1'b0);
        wr(OFF_PENDING, 32'h1);
        $display("test stop entry done");
    endtask : t_stop_ok

    task automatic t_stop_bad();
        wr(OFF_CONTROL, 32'h4);
        wr(OFF_CONTROL, 32'h0);
        wr(OFF_CONTROL, 32'h4);
        `CHK(stop_request, 1'b0, "no stop in interrupt mode")
        rchk(OFF_CONTROL, 32'h0, "stop bit clear");
        wr(OFF_CONTROL, 32'h5);
        wr(OFF_MASK, 32'h0000_0001);
        rchk(OFF_CONTROL, 32'h1, "unit write breaks");
        wr(OFF_CONTROL, 32'h5);
        repeat (SEQ_TIMEOUT_CYC + 4) @(posedge sys_clk);
        rchk(OFF_CONTROL, 32'h1, "timeout clears stop");
        wr(OFF_CONTROL, 32'h5);
        repeat (SEQ_TIMEOUT_CYC / 2) @(posedge sys_clk);
        wr(OFF_CONTROL, 32'h1);
        repeat (SEQ_TIMEOUT_CYC / 2) @(posedge sys_clk);
        wr(OFF_CONTROL, 32'h5);
        `CHK(stop_request, 1'b0, "slow sequence refused")
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h5);
        `CHK(stop_request, 1'b0, "late finish refused")
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h5);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h1);
        wr(OFF_CONTROL, 32'h5);
        `CHK(stop_request, 1'b0, "two zeros abandon")
        $display("test stop refusals done");
    endtask : t_stop_bad

    ////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
        {s_axi_bready, s_axi_rready} = 2'b11;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        ext_req = 5'h00;
        int_req = 10'h000;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_lines();
        t_stop_ok();
        t_stop_bad();
        stop_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #(CLK_PERIOD_NS * 5000);
        `CHK(1'b0, 1'b1, "watchdog expired")
        stop_test();
    end
endmodule : test_wakeup_interrupt_unit
